// ==== rtl/eeu_pkg.sv ====
// Shared constants of the external line event unit
`default_nettype none
package eeu_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int EEU_NLINES = 21;
    localparam int EEU_NPINS = 16;
    localparam int EEU_NGPIO = 114;
    localparam int EEU_SEL_W = 7;
    localparam int EEU_ADDR_W = 12;
    localparam int EEU_DATA_W = 32;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] EEU_OFF_IMASK = 12'h000;
    localparam logic [11:0] EEU_OFF_EMASK = 12'h004;
    localparam logic [11:0] EEU_OFF_RISE = 12'h008;
    localparam logic [11:0] EEU_OFF_FALL = 12'h00C;
    localparam logic [11:0] EEU_OFF_SWTRIG = 12'h010;
    localparam logic [11:0] EEU_OFF_PEND = 12'h014;
    localparam logic [11:0] EEU_OFF_OVR = 12'h018;
    localparam logic [11:0] EEU_OFF_OVRMASK = 12'h01C;
    localparam logic [11:0] EEU_OFF_MUX_BASE = 12'h040;
    localparam logic [11:0] EEU_OFF_MUX_LAST = 12'h07C;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int EEU_MUX_IDX_LSB = 2;
    localparam int EEU_MUX_IDX_W = 4;
    localparam logic [31:0] EEU_RST_LINES = 32'h0000_0000;
    localparam logic [6:0] EEU_RST_SEL = 7'h00;
endpackage
`default_nettype wire

// ==== rtl/eeu_edge_cell.sv ====
// One edge capture cell: asynchronous edge latches and their crossing into pclk
`default_nettype none
module eeu_edge_cell
    import eeu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic line_in,
    output logic rise_pulse,
    output logic fall_pulse
);
    // ****************************************
    // Asynchronous edge latches
    // ****************************************
    logic rise_tgl_r;
    logic fall_tgl_r;
    always_ff @(posedge line_in or negedge presetn) begin
        if (!presetn) begin
            rise_tgl_r <= 1'b0;
        end else begin
            rise_tgl_r <= ~rise_tgl_r;
        end
    end
    always_ff @(negedge line_in or negedge presetn) begin
        if (!presetn) begin
            fall_tgl_r <= 1'b0;
        end else begin
            fall_tgl_r <= ~fall_tgl_r;
        end
    end
    // ****************************************
    // Synchronisers and toggle detection
    // ****************************************
    logic [2:0] rise_sync_r;
    logic [2:0] fall_sync_r;
    logic [2:0] rise_sync_nxt;
    logic [2:0] fall_sync_nxt;
    always_comb begin
        rise_sync_nxt = {rise_sync_r[1:0], rise_tgl_r};
        fall_sync_nxt = {fall_sync_r[1:0], fall_tgl_r};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_sync_r <= 3'h0;
            fall_sync_r <= 3'h0;
        end else begin
            rise_sync_r <= rise_sync_nxt;
            fall_sync_r <= fall_sync_nxt;
        end
    end
    assign rise_pulse = rise_sync_r[1] ^ rise_sync_r[2];
    assign fall_pulse = fall_sync_r[1] ^ fall_sync_r[2];
endmodule
`default_nettype wire

// ==== rtl/eeu_pin_mux.sv ====
// Pin selector: picks one general-purpose input for an external line
`default_nettype none
module eeu_pin_mux
    import eeu_pkg::*;
#(
    parameter int NGPIO = EEU_NGPIO
)
(
    input wire logic [NGPIO-1:0] gpio_in,
    input wire logic [EEU_SEL_W-1:0] sel,
    output logic line_out
);
    // select one pin, out of range reads low
    always_comb begin
        line_out = 1'b0;
        if (int'(sel) < NGPIO) begin
            line_out = gpio_in[sel];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/eeu_top.sv ====
// Top of the external line event unit with its APB register file
//
// What this block does
// - There are 21 independent edge lines, each able to raise an interrupt request and an event request.
// - Each line has its own rising-edge and falling-edge enables, so rising, falling or both edges trigger.
// - Each line has its own interrupt mask and event mask; a masked line forwards no request, but its overrun bit still raises irq when its ovrmask bit is set.
// - Each qualifying edge sets that line's pending bit, which software can read.
// - Edges are latched asynchronously before synchronisation, so pulses shorter than a pclk period are caught.
// - Sixteen lines take their input from a general-purpose pin picked by a selector out of up to 114 pins.
`default_nettype none
module eeu_top
    import eeu_pkg::*;
#(
    parameter int NLINES = EEU_NLINES,
    parameter int NPINS = EEU_NPINS,
    parameter int NGPIO = EEU_NGPIO
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [EEU_ADDR_W-1:0] paddr,
    input wire logic [EEU_DATA_W-1:0] pwdata,
    output logic [EEU_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NGPIO-1:0] gpio_in,
    input wire logic [NLINES-NPINS-1:0] int_src,
    output logic [NLINES-1:0] irq_req,
    output logic [NLINES-1:0] evt_req,
    output logic irq
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    if (NLINES > 32 || NLINES <= NPINS || NPINS > 16 || NPINS < 1) begin : g_bad_lines
        $error("eeu_top: line counts out of range");
    end
    if (NGPIO < 1 || NGPIO > 128) begin : g_bad_gpio
        $error("eeu_top: pin count out of range");
    end

    // ****************************************
    // Address decode helpers
    // ****************************************
    function automatic logic [EEU_MUX_IDX_W-1:0] mux_idx(input logic [EEU_ADDR_W-1:0] a);
        mux_idx = a[EEU_MUX_IDX_LSB +: EEU_MUX_IDX_W];
    endfunction

    function automatic logic is_mux(input logic [EEU_ADDR_W-1:0] a);
        logic [EEU_MUX_IDX_W-1:0] idx;
        idx = mux_idx(a);
        is_mux = (a >= EEU_OFF_MUX_BASE) && (a <= EEU_OFF_MUX_LAST) && (a[1:0] == 2'b00)
                 && (int'(idx) < NPINS);
    endfunction

    function automatic logic is_mapped(input logic [EEU_ADDR_W-1:0] a);
        is_mapped = is_mux(a);
        case (a)
            EEU_OFF_IMASK, EEU_OFF_EMASK, EEU_OFF_RISE, EEU_OFF_FALL, EEU_OFF_SWTRIG,
            EEU_OFF_PEND, EEU_OFF_OVR, EEU_OFF_OVRMASK: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = is_mux(a);
            end
        endcase
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [NLINES-1:0] imask_r, imask_nxt;
    logic [NLINES-1:0] emask_r, emask_nxt;
    logic [NLINES-1:0] rise_en_r, rise_en_nxt;
    logic [NLINES-1:0] fall_en_r, fall_en_nxt;
    logic [NLINES-1:0] swtrig_r, swtrig_nxt;
    logic [NLINES-1:0] pend_r, pend_nxt;
    logic [NLINES-1:0] ovr_r, ovr_nxt;
    logic [NLINES-1:0] ovrmask_r, ovrmask_nxt;
    logic [NLINES-1:0] evt_r, evt_nxt;
    logic [EEU_SEL_W-1:0] sel_r [NPINS];
    logic [EEU_SEL_W-1:0] sel_nxt [NPINS];
    logic [EEU_DATA_W-1:0] prdata_r, prdata_nxt;

    // ****************************************
    // Line sources and edge capture
    // ****************************************
    logic [NLINES-1:0] line_src;
    logic [NLINES-1:0] rise_p;
    logic [NLINES-1:0] fall_p;

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            eeu_pin_mux #(.NGPIO(NGPIO)) u_mux (
                .gpio_in(gpio_in),
                .sel(sel_r[g]),
                .line_out(line_src[g])
            );
        end
        for (g = 0; g < NLINES; g++) begin : g_line
            if (g >= NPINS) begin : g_int
                assign line_src[g] = int_src[g-NPINS];
            end
            eeu_edge_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .line_in(line_src[g]),
                .rise_pulse(rise_p[g]),
                .fall_pulse(fall_p[g])
            );
        end
    endgenerate

    // ****************************************
    // Bus phases
    // ****************************************
    logic setup_ph;
    logic wr_acc;
    logic rd_acc;
    logic [NLINES-1:0] wdat;
    logic [NLINES-1:0] det;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite && is_mapped(paddr);
    assign rd_acc = psel && penable && !pwrite;
    assign wdat = pwdata[NLINES-1:0];

    // ****************************************
    // Configuration next state
    // ****************************************
    always_comb begin
        imask_nxt = imask_r;
        emask_nxt = emask_r;
        rise_en_nxt = rise_en_r;
        fall_en_nxt = fall_en_r;
        ovrmask_nxt = ovrmask_r;
        for (int i = 0; i < NPINS; i++) begin
            sel_nxt[i] = sel_r[i];
        end
        if (wr_acc) begin
            case (paddr)
                EEU_OFF_IMASK: begin
                    imask_nxt = wdat;
                end
                EEU_OFF_EMASK: begin
                    emask_nxt = wdat;
                end
                EEU_OFF_RISE: begin
                    rise_en_nxt = wdat;
                end
                EEU_OFF_FALL: begin
                    fall_en_nxt = wdat;
                end
                EEU_OFF_OVRMASK: begin
                    ovrmask_nxt = wdat;
                end
                default: begin
                    if (is_mux(paddr)) begin
                        sel_nxt[mux_idx(paddr)] = pwdata[EEU_SEL_W-1:0];
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_r <= '0;
            emask_r <= '0;
            rise_en_r <= '0;
            fall_en_r <= '0;
            ovrmask_r <= '0;
            for (int i = 0; i < NPINS; i++) begin
                sel_r[i] <= EEU_RST_SEL;
            end
        end else begin
            imask_r <= imask_nxt;
            emask_r <= emask_nxt;
            rise_en_r <= rise_en_nxt;
            fall_en_r <= fall_en_nxt;
            ovrmask_r <= ovrmask_nxt;
            for (int i = 0; i < NPINS; i++) begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    // ****************************************
    // Line status next state
    // ****************************************
    always_comb begin
        swtrig_nxt = '0;
        det = (rise_p & rise_en_r) | (fall_p & fall_en_r) | swtrig_r;
        pend_nxt = pend_r | det;
        ovr_nxt = ovr_r | (det & pend_r);
        evt_nxt = det & emask_r;
        if (wr_acc && paddr == EEU_OFF_SWTRIG) begin
            swtrig_nxt = wdat;
        end
        // write one clears, new edge wins
        if (wr_acc && paddr == EEU_OFF_PEND) begin
            pend_nxt = (pend_r & ~wdat) | det;
        end
        // Read clears overrun status, new overrun wins
        if (rd_acc && paddr == EEU_OFF_OVR) begin
            ovr_nxt = det & pend_r;
        end
    end

    // ****************************************
    // Line status registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swtrig_r <= '0;
            pend_r <= '0;
            ovr_r <= '0;
            evt_r <= '0;
        end else begin
            swtrig_r <= swtrig_nxt;
            pend_r <= pend_nxt;
            ovr_r <= ovr_nxt;
            evt_r <= evt_nxt;
        end
    end

    // ****************************************
    // Read data next state
    // ****************************************
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup_ph) begin
            prdata_nxt = EEU_RST_LINES;
            case (paddr)
                EEU_OFF_IMASK: begin
                    prdata_nxt[NLINES-1:0] = imask_r;
                end
                EEU_OFF_EMASK: begin
                    prdata_nxt[NLINES-1:0] = emask_r;
                end
                EEU_OFF_RISE: begin
                    prdata_nxt[NLINES-1:0] = rise_en_r;
                end
                EEU_OFF_FALL: begin
                    prdata_nxt[NLINES-1:0] = fall_en_r;
                end
                EEU_OFF_PEND: begin
                    prdata_nxt[NLINES-1:0] = pend_r;
                end
                EEU_OFF_OVR: begin
                    prdata_nxt[NLINES-1:0] = ovr_r;
                end
                EEU_OFF_OVRMASK: begin
                    prdata_nxt[NLINES-1:0] = ovrmask_r;
                end
                default: begin
                    if (is_mux(paddr)) begin
                        prdata_nxt[EEU_SEL_W-1:0] = sel_r[mux_idx(paddr)];
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Read data register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= EEU_RST_LINES;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign irq_req = pend_r & imask_r;
    assign evt_req = evt_r;
    assign irq = (|irq_req) || (|(ovr_r & ovrmask_r));
endmodule
`default_nettype wire

// ==== verif/eeu_properties.sv ====
// Port checks of the external line event unit
`default_nettype none
module eeu_properties
    import eeu_pkg::*;
#(
    parameter int NLINES = EEU_NLINES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [EEU_ADDR_W-1:0] paddr,
    input wire logic [EEU_DATA_W-1:0] pwdata,
    input wire logic [EEU_DATA_W-1:0] prdata,
    input wire logic [NLINES-1:0] irq_req,
    input wire logic [NLINES-1:0] evt_req,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic rise3_r;
    logic fall3_r;
    logic [2:0] off_cnt_r;
    logic hold3;
    assign wr = psel && penable && pwrite;
    assign hold3 = rise3_r || fall3_r || irq_req[3] || (wr && (paddr == EEU_OFF_SWTRIG || paddr == EEU_OFF_IMASK));
    // ****************************************
    // Line 3 trigger enable tracking
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise3_r <= 1'b0;
            fall3_r <= 1'b0;
            off_cnt_r <= 3'h0;
        end else begin
            if (wr && paddr == EEU_OFF_RISE) rise3_r <= pwdata[3];
            if (wr && paddr == EEU_OFF_FALL) fall3_r <= pwdata[3];
            off_cnt_r <= hold3 ? 3'h0 : ((off_cnt_r == 3'h7) ? 3'h7 : off_cnt_r + 3'h1);
        end
    end
    property p_irq_or;
        (|irq_req) |-> irq;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq low with a line request");
    property p_no_trig;
        off_cnt_r == 3'h7 |-> !evt_req[3] && !irq_req[3];
    endproperty
    a_no_trig: assert property (p_no_trig) else $error("line without enables fired");
    property p_imask0;
        wr && paddr == EEU_OFF_IMASK && pwdata[NLINES-1:0] == '0 |-> ##[1:2] irq_req == '0;
    endproperty
    a_imask0: assert property (p_imask0) else $error("masked line still requests");
    property p_emask0;
        wr && paddr == EEU_OFF_EMASK && pwdata[NLINES-1:0] == '0 |-> ##2 evt_req == '0;
    endproperty
    a_emask0: assert property (p_emask0) else $error("masked line still signals events");
    property p_hold;
        !wr && !$past(wr) |=> (irq_req & $past(irq_req)) == $past(irq_req);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped without a write");
    property p_pend_read;
        psel && penable && !pwrite && paddr == EEU_OFF_PEND
            |-> (prdata[NLINES-1:0] & $past(irq_req)) == $past(irq_req) && prdata[31:NLINES] == '0;
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending read misses a request");
endmodule
bind eeu_top eeu_properties #(.NLINES(NLINES)) u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .irq_req, .evt_req, .irq);
`default_nettype wire

// ==== verif/eeu_pin_model.sv ====
// Pin and internal source model driving the line inputs
`default_nettype none
module eeu_pin_model
    import eeu_pkg::*;
(
    input wire logic pclk,
    output logic [EEU_NGPIO-1:0] gpio_in,
    output logic [EEU_NLINES-EEU_NPINS-1:0] int_src
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        gpio_in = '0;
        int_src = '0;
    end
    task automatic level(input int idx, input logic v);
        @(posedge pclk);
        if (idx < EEU_NGPIO) gpio_in[idx] <= v;
        else int_src[idx-EEU_NGPIO] <= v;
    endtask
    task automatic pulse(input int idx);
        @(posedge pclk);
        gpio_in[idx] <= 1'b1;
        #4;
        gpio_in[idx] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench of the external line event unit
`default_nettype none
module tb_top
    import eeu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [EEU_ADDR_W-1:0] paddr = '0;
    logic [EEU_DATA_W-1:0] pwdata = '0;
    logic [EEU_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [EEU_NGPIO-1:0] gpio_in;
    logic [4:0] int_src;
    logic [20:0] irq_req;
    logic [20:0] evt_req;
    logic irq;
    logic [32:0] expq[$];
    int miscompares = 0;
    int cmp_count = 0;
    int evt0_cnt = 0;
    int pin;
    logic [31:0] rv;
    always #10 pclk = ~pclk;
    eeu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio_in(gpio_in), .int_src(int_src), .irq_req(irq_req), .evt_req(evt_req), .irq(irq));
    eeu_pin_model pins (.pclk(pclk), .gpio_in(gpio_in), .int_src(int_src));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) expq.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (6) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************************************
    // Read monitor and event counter
    // ****************************************
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk("read", {pslverr, prdata}, (expq.size() > 0) ? expq.pop_front() : 'x);
        end
        if (evt_req[0] === 1'b1) evt0_cnt++;
    end
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hccef));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 32; a += 4) apb(1'b0, a[11:0], '0, 33'h0_0000_0000);
        apb(1'b0, 12'h020, '0, 33'h1_0000_0000);
        rv = $urandom;
        apb(1'b1, EEU_OFF_EMASK, rv, '0);
        apb(1'b0, EEU_OFF_EMASK, '0, {1'b0, rv & 32'h001f_ffff});
        apb(1'b1, EEU_OFF_EMASK, 32'h0000_0000, '0);
        apb(1'b1, EEU_OFF_EMASK, 32'h0000_0001, '0);
        apb(1'b1, EEU_OFF_IMASK, 32'h001f_ffff, '0);
        apb(1'b1, EEU_OFF_RISE, 32'h0001_0005, '0);
        apb(1'b1, EEU_OFF_FALL, 32'h0000_0006, '0);
        pin = $urandom_range(113, 0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 12'(EEU_OFF_MUX_BASE + 4 * k), 32'(pin), '0);
            apb(1'b0, 12'(EEU_OFF_MUX_BASE + 4 * k), '0, 33'(pin));
        end
        pins.level(pin, 1'b1);
        pins.level(114, 1'b1);
        settle();
        apb(1'b0, EEU_OFF_PEND, '0, 33'h0_0001_0005);
        chk("irq_req", 33'(irq_req), 33'h0_0001_0005);
        pins.level(pin, 1'b0);
        settle();
        apb(1'b0, EEU_OFF_PEND, '0, 33'h0_0001_0007);
        apb(1'b0, EEU_OFF_OVR, '0, 33'h0_0000_0004);
        apb(1'b0, EEU_OFF_OVR, '0, 33'h0_0000_0000);
        apb(1'b1, EEU_OFF_IMASK, 32'h0000_0001, '0);
        @(negedge pclk);
        chk("irq_req", 33'(irq_req), 33'h0_0000_0001);
        chk("irq", 33'(irq), 33'h0_0000_0001);
        apb(1'b1, EEU_OFF_IMASK, 32'h0000_0000, '0);
        @(negedge pclk);
        chk("irq", 33'(irq), 33'h0_0000_0000);
        apb(1'b1, EEU_OFF_PEND, 32'h001f_ffff, '0);
        apb(1'b0, EEU_OFF_PEND, '0, 33'h0_0000_0000);
        pins.level(114, 1'b0);
        pins.pulse(pin);
        settle();
        apb(1'b0, EEU_OFF_PEND, '0, 33'h0_0000_0007);
        apb(1'b1, EEU_OFF_OVRMASK, 32'h0000_0004, '0);
        apb(1'b1, EEU_OFF_SWTRIG, 32'h0000_0014, '0);
        apb(1'b0, EEU_OFF_PEND, '0, 33'h0_0000_0017);
        @(negedge pclk);
        chk("irq", 33'(irq), 33'h0_0000_0001);
        apb(1'b0, EEU_OFF_OVR, '0, 33'h0_0000_0004);
        @(negedge pclk);
        chk("irq", 33'(irq), 33'h0_0000_0000);
        chk("evt0", 33'(evt0_cnt), 33'h0_0000_0002);
        conclude();
    end
endmodule
`default_nettype wire
